// ==== hw/fcsq_defines.svh ====
/*
 Timing counts, command codes and status bit positions for the flash command sequencer.
 Assumes inclusion by bare name from hw/; definitions only.
*/
`ifndef FCSQ_DEFINES_SVH
`define FCSQ_DEFINES_SVH

// Command codes
`define FCSQ_CMD_TWO_BYTE 8'hfb
`define FCSQ_CMD_ERASE_ALL 8'ha7
`define FCSQ_CMD_CONFIRM 8'hd0
`define FCSQ_CMD_READ_ARRAY 8'hff
`define FCSQ_CMD_WP_RESET 8'h47
`define FCSQ_CMD_WP_SET 8'h57
`define FCSQ_CMD_CLEAR_STATUS 8'h50
`define FCSQ_CMD_READ_STATUS 8'h70
// Confirm address of the protect sequences
`define FCSQ_WP_ADDR 10'h0ff
// Status byte fields
`define FCSQ_ST_READY 7
`define FCSQ_ST_SUSP 6
`define FCSQ_ST_ERASE_ERR 5
`define FCSQ_ST_WRITE_ERR 4
`define FCSQ_ST_SUPPLY_LOW 3
`define FCSQ_ST_MASK 8'hf8
// Bus timing, ns, and cycle counts at 10 ns
`define FCSQ_CLK_NS 10
`define FCSQ_T_WE_LOW_NS 110
`define FCSQ_T_WE_HIGH_NS 60
`define FCSQ_T_RD_NS 120
`define FCSQ_WE_LOW_CYC ((`FCSQ_T_WE_LOW_NS + `FCSQ_CLK_NS - 1) / `FCSQ_CLK_NS)
`define FCSQ_WE_HIGH_CYC ((`FCSQ_T_WE_HIGH_NS + `FCSQ_CLK_NS - 1) / `FCSQ_CLK_NS)
`define FCSQ_RD_CYC ((`FCSQ_T_RD_NS + `FCSQ_CLK_NS - 1) / `FCSQ_CLK_NS)
// Poll limit before giving up
`define FCSQ_POLL_MAX 20000000

`endif

// ==== hw/fcsq_host.sv ====
/*
 Host-side command sequencer for a clockless parallel flash: drives chip enable, output
 enable, write enable, address and data, and polls the status byte.
 Assumes the testbench resolves the data bus from o_dq_oe_n and samples i_dq at the pin.
*/
// Summary of operation
// - Two-byte write opens with FBH command
// - Poll ready bit, toggling enables per read
// - Erase all: A7H then D0H, poll busy
// - Clear error bits before next operation
// - Status check per write or per series
// - FFH returns device to array read
// - Protect reset 47H, D0H at 0FFH
// - Locked update: reset, erase, set, write
// - Supply low after erase: clear, retry
// - Interrupted erase: clear, reset, retry
`include "fcsq_defines.svh"
`timescale 1ns/10ps
module fcsq_host import fcsq_pkg::*; #(
    parameter int ADDR_W = 19,
    parameter int POLL_MAX = `FCSQ_POLL_MAX
) (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    // User side
    input wire logic i_req_valid,
    input wire fcsq_op_type i_req_op,
    input wire logic [ADDR_W-1:0] i_req_addr,
    input wire logic [7:0] i_req_first,
    input wire logic i_req_first_high,
    input wire logic [7:0] i_req_second,
    output logic o_req_ready,
    output logic o_done,
    output logic [7:0] o_status,
    output logic o_timeout,
    // Flash pins
    output logic o_ce_n,
    output logic o_oe_n,
    output logic o_we_n,
    output logic o_byte_sel,
    output logic [ADDR_W-1:0] o_addr,
    output logic [7:0] o_dq_out,
    output logic o_dq_oe_n,
    input wire logic [7:0] i_dq,
    input wire logic i_ready_busy_n,
    output logic o_reset_powerdown_n
);
    localparam int TW = 26;
    localparam logic [TW-1:0] WL_CYC = TW'(`FCSQ_WE_LOW_CYC);
    localparam logic [TW-1:0] WH_CYC = TW'(`FCSQ_WE_HIGH_CYC);
    localparam logic [TW-1:0] RD_CYC = TW'(`FCSQ_RD_CYC);

    fcsq_state_type state_q; // Sequencer state
    fcsq_op_type op_q; // Operation in progress
    logic [1:0] cyc_q; // Bus write cycle index
    logic [1:0] ncyc_q; // Write cycles for the op
    logic [ADDR_W-1:0] addr_q; // Target address
    logic [7:0] first_q; // First data byte
    logic [7:0] second_q; // Second data byte
    logic first_high_q; // Byte select of first byte
    logic rd_phase_q; // Poll: high when enables are low
    logic [TW-1:0] polls_q; // Poll attempts left
    logic [7:0] dq_s1_q; // Data synchroniser stage one
    logic [7:0] dq_s2_q; // Data synchroniser stage two
    logic t_load; // Reload strobe timer
    logic [TW-1:0] t_count; // Timer load value
    logic t_exp; // Timer finished
    logic [7:0] cyc_data; // Byte of the current write cycle
    logic [ADDR_W-1:0] cyc_addr; // Address of the current cycle
    logic cyc_sel; // Byte select of the current cycle

    fcsq_strobe_timer #(.WIDTH(TW)) u_timer (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_load(t_load),
        .i_count(t_count),
        .o_expired(t_exp)
    );

    // Write cycles each operation issues
    function automatic logic [1:0] op_cycles(input fcsq_op_type op);
        case (op)
            FCSQ_OP_TWO_BYTE: op_cycles = 2'h3;
            FCSQ_OP_ERASE_ALL, FCSQ_OP_WP_RESET, FCSQ_OP_WP_SET: op_cycles = 2'h2;
            FCSQ_OP_STATUS: op_cycles = 2'h0;
            default: op_cycles = 2'h1;
        endcase
    endfunction

    // Operations that end in a busy poll
    function automatic logic op_polls(input fcsq_op_type op);
        op_polls = (op == FCSQ_OP_TWO_BYTE) || (op == FCSQ_OP_ERASE_ALL) ||
            (op == FCSQ_OP_WP_RESET) || (op == FCSQ_OP_WP_SET) || (op == FCSQ_OP_STATUS);
    endfunction

    // Pin data is asynchronous to our clock; two stages before use
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            dq_s1_q <= 8'h00;
            dq_s2_q <= 8'h00;
        end else begin
            dq_s1_q <= i_dq;
            dq_s2_q <= dq_s1_q;
        end
    end

    // Byte, address and select for each write cycle
    always_comb begin
        cyc_data = 8'h00;
        cyc_addr = '0;
        cyc_sel = 1'b0;
        case (op_q)
            FCSQ_OP_TWO_BYTE: begin
                if (cyc_q == 2'h0) begin
                    cyc_data = `FCSQ_CMD_TWO_BYTE;
                end else if (cyc_q == 2'h1) begin
                    cyc_data = first_q;
                    cyc_sel = first_high_q;
                end else begin
                    cyc_data = second_q;
                    cyc_addr = addr_q;
                    cyc_sel = ~first_high_q;
                end
            end
            FCSQ_OP_ERASE_ALL: begin
                cyc_data = (cyc_q == 2'h0) ? `FCSQ_CMD_ERASE_ALL : `FCSQ_CMD_CONFIRM;
            end
            FCSQ_OP_WP_RESET, FCSQ_OP_WP_SET: begin
                if (cyc_q == 2'h0) begin
                    cyc_data = (op_q == FCSQ_OP_WP_RESET) ? `FCSQ_CMD_WP_RESET
                        : `FCSQ_CMD_WP_SET;
                end else begin
                    cyc_data = `FCSQ_CMD_CONFIRM;
                    cyc_addr = ADDR_W'(`FCSQ_WP_ADDR);
                end
            end
            FCSQ_OP_CLEAR: cyc_data = `FCSQ_CMD_CLEAR_STATUS;
            default: cyc_data = `FCSQ_CMD_READ_ARRAY;
        endcase
    end

    // Timer reload on each strobe phase change
    always_comb begin
        t_load = 1'b0;
        t_count = WL_CYC;
        case (state_q)
            FCSQ_LOAD: begin
                t_load = 1'b1;
                t_count = (ncyc_q == 2'h0) ? RD_CYC : WL_CYC;
            end
            FCSQ_WLOW: begin
                t_load = t_exp;
                t_count = WH_CYC;
            end
            FCSQ_WHIGH: begin
                t_load = t_exp;
                t_count = (cyc_q + 2'h1 == ncyc_q) ? RD_CYC : WL_CYC;
            end
            FCSQ_POLL: begin
                t_load = t_exp;
                t_count = RD_CYC;
            end
            default: begin
                t_load = 1'b0;
            end
        endcase
    end

    // Main sequencer; requests only accepted in idle, so none while busy
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_q <= FCSQ_IDLE;
            op_q <= FCSQ_OP_READ_ARRAY;
            cyc_q <= 2'h0;
            ncyc_q <= 2'h0;
            addr_q <= '0;
            first_q <= 8'h00;
            second_q <= 8'h00;
            first_high_q <= 1'b0;
            rd_phase_q <= 1'b0;
            polls_q <= '0;
        end else begin
            case (state_q)
                FCSQ_IDLE: begin
                    if (i_req_valid) begin
                        op_q <= i_req_op;
                        addr_q <= i_req_addr;
                        first_q <= i_req_first;
                        second_q <= i_req_second;
                        first_high_q <= i_req_first_high;
                        ncyc_q <= op_cycles(i_req_op);
                        cyc_q <= 2'h0;
                        state_q <= FCSQ_LOAD;
                    end
                end
                FCSQ_LOAD: begin
                    polls_q <= TW'(POLL_MAX);
                    rd_phase_q <= 1'b1;
                    state_q <= (ncyc_q == 2'h0) ? FCSQ_POLL : FCSQ_WLOW;
                end
                FCSQ_WLOW: begin
                    if (t_exp) begin
                        state_q <= FCSQ_WHIGH;
                    end
                end
                FCSQ_WHIGH: begin
                    if (t_exp) begin
                        if (cyc_q + 2'h1 == ncyc_q) begin
                            rd_phase_q <= 1'b1;
                            state_q <= op_polls(op_q) ? FCSQ_POLL : FCSQ_DONE;
                        end else begin
                            cyc_q <= cyc_q + 2'h1;
                            state_q <= FCSQ_WLOW;
                        end
                    end
                end
                FCSQ_POLL: begin
                    // Each read ends with enables high so the status refreshes
                    if (t_exp) begin
                        rd_phase_q <= ~rd_phase_q;
                        if (rd_phase_q) begin
                            polls_q <= polls_q - 1'b1;
                            if (dq_s2_q[`FCSQ_ST_READY] || polls_q == '0) begin
                                state_q <= FCSQ_DONE;
                            end
                        end
                    end
                end
                FCSQ_DONE: state_q <= FCSQ_IDLE;
                default: state_q <= FCSQ_IDLE;
            endcase
        end
    end

    // Result: masked status byte of the last poll, and timeout flag
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_status <= 8'h00;
            o_timeout <= 1'b0;
        end else if (state_q == FCSQ_LOAD) begin
            o_timeout <= 1'b0;
            o_status <= 8'h00;
        end else if (state_q == FCSQ_POLL && t_exp && rd_phase_q) begin
            // Error bits go to the user who decides recovery
            o_status <= dq_s2_q & `FCSQ_ST_MASK;
            o_timeout <= !dq_s2_q[`FCSQ_ST_READY] && polls_q == '0;
        end
    end

    // Pin drivers registered for glitch-free strobes
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_ce_n <= 1'b1;
            o_oe_n <= 1'b1;
            o_we_n <= 1'b1;
            o_dq_oe_n <= 1'b1;
            o_addr <= '0;
            o_byte_sel <= 1'b0;
            o_dq_out <= 8'h00;
        end else begin
            o_we_n <= !((state_q == FCSQ_LOAD && ncyc_q != 2'h0) ||
                (state_q == FCSQ_WLOW && !t_exp) ||
                (state_q == FCSQ_WHIGH && t_exp && cyc_q + 2'h1 != ncyc_q));
            o_oe_n <= !(state_q == FCSQ_POLL && rd_phase_q && !t_exp);
            o_ce_n <= (state_q == FCSQ_IDLE) || (state_q == FCSQ_DONE) ||
                (state_q == FCSQ_POLL && !(rd_phase_q && !t_exp));
            o_dq_oe_n <= !(state_q == FCSQ_LOAD && ncyc_q != 2'h0 ||
                state_q == FCSQ_WLOW || state_q == FCSQ_WHIGH);
            o_addr <= cyc_addr;
            o_byte_sel <= cyc_sel;
            o_dq_out <= cyc_data;
        end
    end

    // Device stays out of power-down while the host runs
    assign o_reset_powerdown_n = i_nrst;
    assign o_req_ready = (state_q == FCSQ_IDLE);
    assign o_done = (state_q == FCSQ_DONE);

    // Write strobe never low while output enable is low
    chk_strobe_excl: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        !(!o_we_n && !o_oe_n))
        else $error("write and output enable low together");

    // A poll read is followed by chip enable high before the next
    chk_poll_toggle: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        $rose(o_oe_n) && state_q == FCSQ_POLL |-> o_ce_n)
        else $error("chip enable not toggled between polls");

    // Two-byte first cycle carries the opening command
    chk_two_byte_cmd: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        state_q == FCSQ_WLOW && op_q == FCSQ_OP_TWO_BYTE && cyc_q == 2'h0
        |-> ##1 o_dq_out == 8'hfb)
        else $error("two-byte command code wrong");

    // Second data byte uses inverted select
    chk_sel_invert: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        state_q == FCSQ_WLOW && op_q == FCSQ_OP_TWO_BYTE && cyc_q == 2'h2
        |-> ##1 o_byte_sel == !first_high_q && o_dq_out == second_q)
        else $error("second byte select not inverted");

    // First data byte uses requested select
    chk_sel_first: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        state_q == FCSQ_WLOW && op_q == FCSQ_OP_TWO_BYTE && cyc_q == 2'h1
        |-> ##1 o_byte_sel == first_high_q)
        else $error("first byte select wrong");

    // Protect reset confirm at the fixed address
    chk_wp_addr: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        state_q == FCSQ_WLOW && op_q == FCSQ_OP_WP_RESET && cyc_q == 2'h1
        |-> ##1 o_addr == ADDR_W'(10'h0ff) && o_dq_out == 8'hd0)
        else $error("protect confirm address wrong");

    // Erase all sends A7 then D0
    chk_erase_cmd: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        state_q == FCSQ_WLOW && op_q == FCSQ_OP_ERASE_ALL
        |-> ##1 o_dq_out == ((cyc_q == 2'h0) ? 8'ha7 : 8'hd0))
        else $error("erase all command wrong");

    // No request taken while busy: captured request frozen outside idle
    chk_no_accept_busy: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        state_q != FCSQ_IDLE |=> $stable(op_q) && $stable(addr_q))
        else $error("request taken while sequence runs");

    // Read array sends FF
    chk_read_array: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        state_q == FCSQ_WLOW && op_q == FCSQ_OP_READ_ARRAY |-> ##1 o_dq_out == 8'hff)
        else $error("read array code wrong");
endmodule

// ==== hw/fcsq_pkg.sv ====
/*
 Types for the flash command sequencer.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package fcsq_pkg;
    // Operations taken at the user port
    typedef enum logic [2:0] {
        FCSQ_OP_TWO_BYTE = 3'h0,
        FCSQ_OP_ERASE_ALL = 3'h1,
        FCSQ_OP_WP_RESET = 3'h2,
        FCSQ_OP_WP_SET = 3'h3,
        FCSQ_OP_CLEAR = 3'h4,
        FCSQ_OP_READ_ARRAY = 3'h5,
        FCSQ_OP_STATUS = 3'h6
    } fcsq_op_type;

    // Sequencer states, one-hot
    typedef enum logic [5:0] {
        FCSQ_IDLE = 6'h01,
        FCSQ_LOAD = 6'h02,
        FCSQ_WLOW = 6'h04,
        FCSQ_WHIGH = 6'h08,
        FCSQ_POLL = 6'h10,
        FCSQ_DONE = 6'h20
    } fcsq_state_type;
endpackage

// ==== hw/fcsq_strobe_timer.sv ====
/*
 Down-counter giving the pulse widths of the flash strobes.
 Assumes a load pulse from the sequencer in the same clock domain.
*/
`timescale 1ns/10ps
module fcsq_strobe_timer import fcsq_pkg::*; #(
    parameter int WIDTH = 26
) (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_load,
    input wire logic [WIDTH-1:0] i_count,
    output logic o_expired
);
    logic [WIDTH-1:0] cnt_q; // Cycles left

    // Load wins; otherwise count down to zero
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_q <= '0;
        end else if (i_load) begin
            cnt_q <= i_count;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    // Expired once the count sits at zero; not gated by the load, since the
    // sequencer derives its reload from this flag and a gate would loop back
    assign o_expired = (cnt_q == '0);
endmodule

// ==== test/fcsq_flash_model.sv ====
/*
 Behavioural flash device for the sequencer: write-strobe command decode, status byte,
 protect state and one block lock bit.
 Assumes the bench resolves the shared data lines from both drive enables.
*/
`timescale 1ns/10ps
module fcsq_flash_model #(
    parameter int WRITE_NS = 200, // Short busy times keep the run brief
    parameter int ERASE_NS = 600
) (
    input wire logic i_ce_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    input wire logic i_byte_sel,
    input wire logic [18:0] i_addr,
    input wire logic [7:0] i_dq,
    input wire logic i_stuck,
    input wire logic [1:0] i_fail,
    output logic [7:0] o_dq,
    output logic o_drive
);
    logic [7:0] cmd_q = 8'h00; // Pending command byte
    logic [1:0] phase_q = 2'h0; // Two-byte data cycle
    logic sel_q = 1'b0; // Select of first byte
    logic [15:0] data_q = 16'h0000; // Data holding register
    logic [18:0] loc_q = 19'h00000; // Last write location
    logic [5:3] flags_q = 3'h0; // Error and supply flags
    logic unprot_q = 1'b0; // Protection lifted
    logic locked_q = 1'b1; // Lock of the written block
    logic array_q = 1'b0; // Array read mode
    logic ready_q = 1'b1; // Machine ready
    logic [7:0] shown_q = 8'h00; // Value on the data lines
    int erases_q = 0; // Erase count
    realtime busy_until = 0.0;

    // Ready follows the busy time; stuck holds it busy for the timeout case
    always #5 ready_q = ($realtime >= busy_until) && !i_stuck;
    // Refreshed only when an enable falls, so a held read goes stale
    always @(negedge i_ce_n or negedge i_oe_n) begin
        shown_q = array_q ? 8'h3c : {ready_q, 1'b0, flags_q, 3'b111};
    end
    assign o_drive = !i_ce_n && !i_oe_n;
    assign o_dq = shown_q;
    // Writes land on the rising write strobe
    always @(posedge i_we_n) begin
        if (!i_ce_n) begin
            if (phase_q == 2'h1) begin
                sel_q = i_byte_sel;
                if (i_byte_sel) data_q[15:8] = i_dq;
                else data_q[7:0] = i_dq;
                phase_q = 2'h2;
            end else if (phase_q == 2'h2) begin
                if (sel_q) data_q[7:0] = i_dq;
                else data_q[15:8] = i_dq;
                loc_q = i_addr;
                phase_q = 2'h0;
                if (locked_q && !unprot_q) flags_q[4] = 1'b1;
                busy_until = $realtime + WRITE_NS;
            end else if (cmd_q == 8'ha7 && i_dq == 8'hd0) begin
                erases_q++;
                flags_q[5:4] = i_fail;
                if (unprot_q) locked_q = 1'b0;
                busy_until = $realtime + ERASE_NS;
                cmd_q = 8'h00;
            end else if ((cmd_q == 8'h47 || cmd_q == 8'h57) && i_dq == 8'hd0
                    && i_addr[9:0] == 10'h0ff) begin
                unprot_q = (cmd_q == 8'h47);
                cmd_q = 8'h00;
            end else begin
                cmd_q = i_dq;
                if (i_dq == 8'hfb) phase_q = 2'h1;
                if (i_dq == 8'h50) flags_q = 3'h0;
                array_q = (i_dq == 8'hff);
            end
        end
    end
endmodule

// ==== test/flash_command_sequencer_tb_top.sv ====
/*
 Self-checking bench: the sequencer drives the flash model; each task but do_op and wrap_up is one scenario.
 Assumes the model files and a short poll limit on the sequencer.
*/
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin mismatches++; \
    $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module flash_command_sequencer_tb_top;
    import fcsq_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic req_valid = 1'b0; // User request strobe
    fcsq_op_type req_op = FCSQ_OP_STATUS;
    logic [18:0] req_addr = 19'h00000;
    logic [7:0] req_first = 8'h00;
    logic req_high = 1'b0;
    logic [7:0] req_second = 8'h00;
    logic stuck = 1'b0; // Holds the model busy
    logic [1:0] fail = 2'h0; // Erase outcome to report
    logic req_ready, done, tmo, ce_n, oe_n, we_n, bsel, dq_oe_n, drive, rpd_n;
    logic [7:0] status, dq_out, dev_dq;
    logic [18:0] addr;
    logic [7:0] last_dq = 8'h00; // Last driven level
    wire [7:0] dq_bus = !dq_oe_n ? dq_out : (drive ? dev_dq : ~last_dq); // Released: inverted
    int mismatches = 0;
    int samples_checked = 0;

    initial forever #5 clk = ~clk;
    always @(posedge clk) if (!dq_oe_n || drive) last_dq <= dq_bus;

    fcsq_host #(.ADDR_W(19), .POLL_MAX(50)) dut_u (.i_ref_clk(clk), .i_nrst(nrst),
        .i_req_valid(req_valid), .i_req_op(req_op), .i_req_addr(req_addr),
        .i_req_first(req_first), .i_req_first_high(req_high), .i_req_second(req_second),
        .o_req_ready(req_ready), .o_done(done), .o_status(status), .o_timeout(tmo),
        .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n), .o_byte_sel(bsel), .o_addr(addr),
        .o_dq_out(dq_out), .o_dq_oe_n(dq_oe_n), .i_dq(dq_bus), .i_ready_busy_n(1'b1),
        .o_reset_powerdown_n(rpd_n));
    fcsq_flash_model flash_u (.i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n),
        .i_byte_sel(bsel), .i_addr(addr), .i_dq(dq_bus), .i_stuck(stuck), .i_fail(fail),
        .o_dq(dev_dq), .o_drive(drive));

    // Verdict and end of run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // One request, held one edge, then wait for the done pulse
    task automatic do_op(input fcsq_op_type op, input logic [18:0] a, input logic [7:0] f,
            input logic h, input logic [7:0] s);
        int n;
        n = 0;
        @(negedge clk);
        req_valid = 1'b1;
        req_op = op;
        req_addr = a;
        req_first = f;
        req_high = h;
        req_second = s;
        @(negedge clk);
        req_valid = 1'b0;
        while (done !== 1'b1 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        `CHK("done", 1'b1, done)
    endtask

    // Writes before protect reset hit the lock; byte order checked
    task automatic t_locked_write();
        do_op(FCSQ_OP_TWO_BYTE, 19'h12345, 8'h5a, 1'b1, 8'hc3);
        `CHK("hold reg", 16'h5ac3, flash_u.data_q)
        `CHK("location", 19'h12345, flash_u.loc_q)
        `CHK("status", 8'h90, status)
        do_op(FCSQ_OP_CLEAR, 19'h0, 8'h00, 1'b0, 8'h00);
        do_op(FCSQ_OP_STATUS, 19'h0, 8'h00, 1'b0, 8'h00);
        `CHK("cleared", 8'h80, status)
        `CHK("pin rp", 1'b1, rpd_n)
        $display("test locked_write done");
    endtask

    // Protect reset allows the write; protect set enforces again
    task automatic t_protect();
        do_op(FCSQ_OP_WP_RESET, 19'h0, 8'h00, 1'b0, 8'h00);
        `CHK("unprot", 1'b1, flash_u.unprot_q)
        do_op(FCSQ_OP_TWO_BYTE, 19'h00400, 8'h11, 1'b0, 8'h22);
        `CHK("hold reg", 16'h2211, flash_u.data_q)
        `CHK("status", 8'h80, status)
        do_op(FCSQ_OP_WP_SET, 19'h0, 8'h00, 1'b0, 8'h00);
        do_op(FCSQ_OP_TWO_BYTE, 19'h00401, 8'h33, 1'b1, 8'h44);
        `CHK("status", 8'h90, status)
        do_op(FCSQ_OP_CLEAR, 19'h0, 8'h00, 1'b0, 8'h00);
        $display("test protect done");
    endtask

    // Erase all: success clears the lock, then both error bits reported
    task automatic t_erase();
        do_op(FCSQ_OP_WP_RESET, 19'h0, 8'h00, 1'b0, 8'h00);
        do_op(FCSQ_OP_ERASE_ALL, 19'h0, 8'h00, 1'b0, 8'h00);
        `CHK("erases", 1, flash_u.erases_q)
        `CHK("status", 8'h80, status)
        `CHK("lock", 1'b0, flash_u.locked_q)
        fail = 2'h3;
        do_op(FCSQ_OP_ERASE_ALL, 19'h0, 8'h00, 1'b0, 8'h00);
        `CHK("status", 8'hb0, status)
        fail = 2'h0;
        do_op(FCSQ_OP_CLEAR, 19'h0, 8'h00, 1'b0, 8'h00);
        do_op(FCSQ_OP_WP_SET, 19'h0, 8'h00, 1'b0, 8'h00);
        do_op(FCSQ_OP_TWO_BYTE, 19'h00402, 8'h55, 1'b0, 8'h66);
        `CHK("status", 8'h80, status)
        $display("test erase done");
    endtask

    // Device never ready: poll gives up
    task automatic t_timeout();
        stuck = 1'b1;
        do_op(FCSQ_OP_STATUS, 19'h0, 8'h00, 1'b0, 8'h00);
        `CHK("timeout", 1'b1, tmo)
        `CHK("ready bit", 1'b0, status[7])
        stuck = 1'b0;
        do_op(FCSQ_OP_STATUS, 19'h0, 8'h00, 1'b0, 8'h00);
        `CHK("timeout", 1'b0, tmo)
        `CHK("status", 8'h80, status)
        $display("test timeout done");
    endtask

    // Reset in mid-poll: strobes idle at once, device held in reset, then recovery
    task automatic t_reset();
        stuck = 1'b1;
        @(negedge clk);
        req_valid = 1'b1;
        req_op = FCSQ_OP_STATUS;
        @(negedge clk);
        req_valid = 1'b0;
        repeat (30) @(negedge clk);
        `CHK("busy", 1'b0, req_ready)
        nrst = 1'b0;
        @(negedge clk);
        `CHK("ce in reset", 1'b1, ce_n)
        `CHK("rp in reset", 1'b0, rpd_n)
        stuck = 1'b0;
        nrst = 1'b1;
        repeat (2) @(negedge clk);
        `CHK("ready after reset", 1'b1, req_ready)
        `CHK("oe after reset", 1'b1, oe_n)
        do_op(FCSQ_OP_STATUS, 19'h0, 8'h00, 1'b0, 8'h00);
        `CHK("status", 8'h80, status)
        $display("test reset done");
    endtask

    // Return to array reading
    task automatic t_array();
        do_op(FCSQ_OP_READ_ARRAY, 19'h0, 8'h00, 1'b0, 8'h00);
        `CHK("array mode", 1'b1, flash_u.array_q)
        $display("test array done");
    endtask

    // Main sequence
    initial begin
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        t_locked_write();
        t_protect();
        t_erase();
        t_timeout();
        t_reset();
        t_array();
        wrap_up();
    end

    // Watchdog well past the expected run
    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        wrap_up();
    end
endmodule
